/* src/mrt_defines.svh */
`ifndef MRT_DEFINES_SVH
`define MRT_DEFINES_SVH
// Register offsets (byte addresses on the 16-bit register port).
`define MRT_ADDR_CTL 8'h00
`define MRT_ADDR_CUR_HI 8'h02
`define MRT_ADDR_CUR_LO 8'h04
`define MRT_ADDR_VOLT 8'h06
`define MRT_ADDR_ITEMP 8'h08
`define MRT_ADDR_ETEMP 8'h0a
`define MRT_ADDR_INTERNAL_TEMP_GAIN_CODE 8'h0c
`define MRT_ADDR_INTERNAL_TEMP_OFFSET_CODE 8'h0e
`define MRT_ADDR_EXTERNAL_TEMP_GAIN_CODE 8'h10
`define MRT_ADDR_EXTERNAL_TEMP_OFFSET_CODE 8'h12
`define MRT_ADDR_CAL_BASE 8'h14
`define MRT_ADDR_STATUS 8'h16
// Control register fields.
`define MRT_CTL_CUR_EN 0
`define MRT_CTL_VOLT_EN 1
`define MRT_CTL_ITEMP_EN 2
`define MRT_CTL_ETEMP_EN 3
`define MRT_CTL_CHOP_EN 4
`define MRT_CTL_CUR_IRQ_EN 5
`define MRT_CTL_VOLT_IRQ_EN 6
// Current result word layout.
`define MRT_CUR_GAIN_LSB 21
`define MRT_CUR_MAX 17'h0ffff
`define MRT_CUR_MIN 17'h10000
// Voltage limits.
`define MRT_VOLT_MAX 16'hffff
`define MRT_VOLT_MIN 16'h0000
// Temperature channel.
`define MRT_TEMP_DECIM 8'd128
`define MRT_TEMP_MAX 16'hffff
`define MRT_GAIN_BASE 10'd896
`define MRT_GAIN_SHIFT 10
`define MRT_OFF_SHIFT 2
`define MRT_CAL_THRESH 16'h0200
// Reset values.
`define MRT_CTL_RST 8'h00
`define MRT_GAIN_RST 8'h80
`define MRT_OFF_RST 8'h00
`define MRT_CAL_BASE_RST 16'h0000
`endif

/* src/mrt_pkg.sv */
package mrt_pkg;
   // Temperature channel sequencer states.
   typedef enum logic [1:0] {
      TS_IDLE,
      TS_CONVERT,
      TS_UPDATE
   } mrt_temp_state_t;
endpackage

/* src/mrt_top.sv */
`timescale 1ns/10ps
`include "mrt_defines.svh"
module mrt_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic low_power_mode,
   input wire logic [23:0] cur_data,
   input wire logic [2:0] cur_gain,
   input wire logic cur_valid,
   input wire logic [19:0] volt_data,
   input wire logic volt_valid,
   input wire logic temp_bit,
   input wire logic temp_bit_valid,
   input wire logic trim_load,
   input wire logic [7:0] trim_internal_temp_gain_code,
   input wire logic [7:0] trim_internal_temp_offset_code,
   output logic cur_run,
   output logic volt_run,
   output logic temp_run,
   output logic cur_start,
   output logic volt_start,
   output logic cur_irq_req,
   output logic volt_irq_req,
   output logic temp_chop_phase,
   output logic temp_sel_ext,
   output logic external_sensor_supply_output,
   output logic cal_request
);

   // ************************************************
   // Arithmetic helpers
   // ************************************************

   // Gain then offset on a 16-bit code, saturated at both ends.
   function automatic logic [15:0] mrt_comp(input logic [15:0] raw,
                                            input logic [7:0] gain,
                                            input logic [7:0] off);
      logic [26:0] prod;
      logic signed [18:0] sum;
      // The factor reaches 1151, so it is widened before the add, and the
      // product needs 27 bits to hold a full-scale code times that factor.
      prod = 27'(raw) * (27'(`MRT_GAIN_BASE) + 27'(gain));
      sum = $signed({2'b00, prod[`MRT_GAIN_SHIFT +: 17]})
            + (19'($signed(off)) <<< `MRT_OFF_SHIFT);
      if (sum < 0) begin
         mrt_comp = 16'h0000;
      end else if (sum > 19'sh0ffff) begin
         mrt_comp = `MRT_TEMP_MAX;
      end else begin
         mrt_comp = sum[15:0];
      end
   endfunction

   // Signed current sample clamped into the 17-bit result range.
   function automatic logic [16:0] mrt_clamp_cur(input logic [23:0] d);
      if ($signed(d) > 24'sh00ffff) begin
         mrt_clamp_cur = `MRT_CUR_MAX;
      end else if ($signed(d) < -24'sh010000) begin
         mrt_clamp_cur = `MRT_CUR_MIN;
      end else begin
         mrt_clamp_cur = d[16:0];
      end
   endfunction

   // Signed voltage sample clamped into the unsigned 16-bit range.
   function automatic logic [15:0] mrt_clamp_volt(input logic [19:0] d);
      if ($signed(d) < 0) begin
         mrt_clamp_volt = `MRT_VOLT_MIN;
      end else if (d > 20'h0ffff) begin
         mrt_clamp_volt = `MRT_VOLT_MAX;
      end else begin
         mrt_clamp_volt = d[15:0];
      end
   endfunction

   // ************************************************
   // Register file and current/voltage results
   // ************************************************

   logic [7:0] ctl_reg, ctl_next;
   logic [23:0] cur_res_reg, cur_res_next;
   logic [15:0] volt_res_reg, volt_res_next;
   logic [7:0] internal_temp_gain_code_reg, internal_temp_gain_code_next;
   logic [7:0] internal_temp_offset_code_reg, internal_temp_offset_code_next;
   logic [7:0] external_temp_gain_code_reg, external_temp_gain_code_next;
   logic [7:0] external_temp_offset_code_reg, external_temp_offset_code_next;
   logic [15:0] cal_base_reg, cal_base_next;
   logic [15:0] rdata_reg, rdata_next;
   logic cur_start_reg, cur_start_next;
   logic volt_start_reg, volt_start_next;
   logic cur_irq_reg, cur_irq_next;
   logic volt_irq_reg, volt_irq_next;
   logic cur_run_reg, cur_run_next;
   logic volt_run_reg, volt_run_next;
   logic [15:0] itemp_res_reg;
   logic [15:0] etemp_res_reg;
   mrt_pkg::mrt_temp_state_t ts_reg;
   logic sel_ext_reg;
   logic cal_reg;
   logic ctl_wr;
   logic [7:0] ctl_w;

   assign ctl_wr = reg_wr && (reg_addr == `MRT_ADDR_CTL);
   assign ctl_w = reg_wdata[7:0];

   // Register writes, result capture and the synchronous start pulses.
   always_comb begin
      ctl_next = ctl_reg;
      internal_temp_gain_code_next = internal_temp_gain_code_reg;
      internal_temp_offset_code_next = internal_temp_offset_code_reg;
      external_temp_gain_code_next = external_temp_gain_code_reg;
      external_temp_offset_code_next = external_temp_offset_code_reg;
      cal_base_next = cal_base_reg;
      cur_res_next = cur_res_reg;
      volt_res_next = volt_res_reg;
      cur_start_next = 1'b0;
      volt_start_next = 1'b0;
      cur_irq_next = 1'b0;
      volt_irq_next = 1'b0;
      rdata_next = 16'h0000;
      // Factory trim only feeds the internal sensor's codes.
      if (trim_load) begin
         internal_temp_gain_code_next = trim_internal_temp_gain_code;
         internal_temp_offset_code_next = trim_internal_temp_offset_code;
      end
      if (reg_wr) begin
         case (reg_addr)
            `MRT_ADDR_CTL: ctl_next = ctl_w;
            `MRT_ADDR_INTERNAL_TEMP_GAIN_CODE: internal_temp_gain_code_next = reg_wdata[7:0];
            `MRT_ADDR_INTERNAL_TEMP_OFFSET_CODE: internal_temp_offset_code_next = reg_wdata[7:0];
            `MRT_ADDR_EXTERNAL_TEMP_GAIN_CODE: external_temp_gain_code_next = reg_wdata[7:0];
            `MRT_ADDR_EXTERNAL_TEMP_OFFSET_CODE: external_temp_offset_code_next = reg_wdata[7:0];
            `MRT_ADDR_CAL_BASE: cal_base_next = reg_wdata;
            default: ;
         endcase
      end
      // A rising enable restarts its channel; one write raising both starts
      // them in the same cycle, which keeps the two sample streams aligned.
      if (ctl_wr) begin
         cur_start_next = ctl_w[`MRT_CTL_CUR_EN] && !ctl_reg[`MRT_CTL_CUR_EN];
         volt_start_next = ctl_w[`MRT_CTL_VOLT_EN] && !ctl_reg[`MRT_CTL_VOLT_EN];
      end
      // Current keeps running through low power; voltage does not, so
      // software has to restart both after wake-up to resynchronise.
      cur_run_next = ctl_next[`MRT_CTL_CUR_EN];
      volt_run_next = ctl_next[`MRT_CTL_VOLT_EN] && !low_power_mode;
      if (cur_valid && cur_run_reg) begin
         cur_res_next = {cur_gain, 4'h0, mrt_clamp_cur(cur_data)};
         cur_irq_next = ctl_reg[`MRT_CTL_CUR_IRQ_EN];
      end
      if (volt_valid && volt_run_reg) begin
         volt_res_next = mrt_clamp_volt(volt_data);
         volt_irq_next = ctl_reg[`MRT_CTL_VOLT_IRQ_EN];
      end
      // Read data appears in the cycle after the strobe; unmapped reads 0.
      if (reg_rd) begin
         case (reg_addr)
            `MRT_ADDR_CTL: rdata_next = {8'h00, ctl_reg};
            `MRT_ADDR_CUR_HI: rdata_next = {8'h00, cur_res_reg[23:16]};
            `MRT_ADDR_CUR_LO: rdata_next = cur_res_reg[15:0];
            `MRT_ADDR_VOLT: rdata_next = volt_res_reg;
            `MRT_ADDR_ITEMP: rdata_next = itemp_res_reg;
            `MRT_ADDR_ETEMP: rdata_next = etemp_res_reg;
            `MRT_ADDR_INTERNAL_TEMP_GAIN_CODE: rdata_next = {8'h00, internal_temp_gain_code_reg};
            `MRT_ADDR_INTERNAL_TEMP_OFFSET_CODE: rdata_next = {8'h00, internal_temp_offset_code_reg};
            `MRT_ADDR_EXTERNAL_TEMP_GAIN_CODE: rdata_next = {8'h00, external_temp_gain_code_reg};
            `MRT_ADDR_EXTERNAL_TEMP_OFFSET_CODE: rdata_next = {8'h00, external_temp_offset_code_reg};
            `MRT_ADDR_CAL_BASE: rdata_next = cal_base_reg;
            `MRT_ADDR_STATUS: rdata_next = {12'h000, cal_reg, sel_ext_reg,
                                            ts_reg != mrt_pkg::TS_IDLE, volt_run_reg};
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   // Register stage for the bus and result group.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctl_reg <= `MRT_CTL_RST;
         internal_temp_gain_code_reg <= `MRT_GAIN_RST;
         internal_temp_offset_code_reg <= `MRT_OFF_RST;
         external_temp_gain_code_reg <= `MRT_GAIN_RST;
         external_temp_offset_code_reg <= `MRT_OFF_RST;
         cal_base_reg <= `MRT_CAL_BASE_RST;
         cur_res_reg <= 24'h000000;
         volt_res_reg <= 16'h0000;
         rdata_reg <= 16'h0000;
         cur_start_reg <= 1'b0;
         volt_start_reg <= 1'b0;
         cur_irq_reg <= 1'b0;
         volt_irq_reg <= 1'b0;
         cur_run_reg <= 1'b0;
         volt_run_reg <= 1'b0;
      end else begin
         ctl_reg <= ctl_next;
         internal_temp_gain_code_reg <= internal_temp_gain_code_next;
         internal_temp_offset_code_reg <= internal_temp_offset_code_next;
         external_temp_gain_code_reg <= external_temp_gain_code_next;
         external_temp_offset_code_reg <= external_temp_offset_code_next;
         cal_base_reg <= cal_base_next;
         cur_res_reg <= cur_res_next;
         volt_res_reg <= volt_res_next;
         rdata_reg <= rdata_next;
         cur_start_reg <= cur_start_next;
         volt_start_reg <= volt_start_next;
         cur_irq_reg <= cur_irq_next;
         volt_irq_reg <= volt_irq_next;
         cur_run_reg <= cur_run_next;
         volt_run_reg <= volt_run_next;
      end
   end

   // ************************************************
   // Temperature channel
   // ************************************************

   mrt_pkg::mrt_temp_state_t ts_next;
   logic [8:0] ones_reg, ones_next;
   logic [7:0] samp_reg, samp_next;
   logic half_reg, half_next;
   logic chop_reg, chop_next;
   logic sel_ext_next;
   logic [15:0] raw_reg, raw_next;
   logic [15:0] itemp_res_next;
   logic [15:0] etemp_res_next;
   logic cal_next;
   logic temp_run_reg, temp_run_next;
   logic supply_reg, supply_next;
   logic it_en;
   logic et_en;
   logic chop_en;
   logic [17:0] scaled;
   logic [15:0] delta;

   assign it_en = ctl_reg[`MRT_CTL_ITEMP_EN];
   assign et_en = ctl_reg[`MRT_CTL_ETEMP_EN];
   assign chop_en = ctl_reg[`MRT_CTL_CHOP_EN];

   // One modulator serves both sensors; the mux select picks the source.
   // Ones are counted over 128 samples, twice when chopping, and the
   // second chopper phase inverts the bit so the offset cancels.
   always_comb begin
      ts_next = ts_reg;
      ones_next = ones_reg;
      samp_next = samp_reg;
      half_next = half_reg;
      chop_next = chop_reg;
      sel_ext_next = sel_ext_reg;
      raw_next = raw_reg;
      itemp_res_next = itemp_res_reg;
      etemp_res_next = etemp_res_reg;
      scaled = chop_en ? {1'b0, ones_reg, 8'h00} : {ones_reg, 9'h000};
      case (ts_reg)
         mrt_pkg::TS_IDLE: begin
            ones_next = 9'h000;
            samp_next = 8'h00;
            half_next = 1'b0;
            chop_next = 1'b0;
            if (it_en || et_en) begin
               sel_ext_next = !it_en;
               ts_next = mrt_pkg::TS_CONVERT;
            end
         end
         mrt_pkg::TS_CONVERT: begin
            if (!(it_en || et_en)) begin
               ts_next = mrt_pkg::TS_IDLE;
            end else if (temp_bit_valid) begin
               ones_next = ones_reg + 9'(temp_bit ^ (chop_en && chop_reg));
               samp_next = samp_reg + 8'd1;
               if (samp_reg == `MRT_TEMP_DECIM - 8'd1) begin
                  samp_next = 8'h00;
                  if (chop_en && !half_reg) begin
                     half_next = 1'b1;
                     chop_next = !chop_reg;
                  end else begin
                     ts_next = mrt_pkg::TS_UPDATE;
                  end
               end
            end
         end
         mrt_pkg::TS_UPDATE: begin
            // Full count would wrap to zero, so it is held at the top code.
            raw_next = (scaled > 18'h0ffff) ? `MRT_TEMP_MAX : scaled[15:0];
            if (!sel_ext_reg) begin
               itemp_res_next = mrt_comp(raw_next, internal_temp_gain_code_reg, internal_temp_offset_code_reg);
            end else begin
               etemp_res_next = mrt_comp(raw_next, external_temp_gain_code_reg, external_temp_offset_code_reg);
            end
            ones_next = 9'h000;
            half_next = 1'b0;
            // Each conversion opens in phase zero, so a phase left high outlives a chopper that
            // software has just switched off only until the conversion in progress ends.
            chop_next = 1'b0;
            sel_ext_next = (it_en && et_en) ? !sel_ext_reg : !it_en;
            ts_next = (it_en || et_en) ? mrt_pkg::TS_CONVERT : mrt_pkg::TS_IDLE;
         end
         default: ts_next = mrt_pkg::TS_IDLE;
      endcase
      // Request a recalibration once the die drifts past the threshold.
      delta = (itemp_res_reg > cal_base_reg) ? itemp_res_reg - cal_base_reg
                                             : cal_base_reg - itemp_res_reg;
      cal_next = it_en && (delta > `MRT_CAL_THRESH);
      // Run and supply flags are registered copies of the next state.
      temp_run_next = (ts_next != mrt_pkg::TS_IDLE);
      supply_next = sel_ext_next && (ts_next != mrt_pkg::TS_IDLE);
   end

   // Register stage for the temperature group.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ts_reg <= mrt_pkg::TS_IDLE;
         ones_reg <= 9'h000;
         samp_reg <= 8'h00;
         half_reg <= 1'b0;
         chop_reg <= 1'b0;
         sel_ext_reg <= 1'b0;
         raw_reg <= 16'h0000;
         itemp_res_reg <= 16'h0000;
         etemp_res_reg <= 16'h0000;
         cal_reg <= 1'b0;
         temp_run_reg <= 1'b0;
         supply_reg <= 1'b0;
      end else begin
         ts_reg <= ts_next;
         ones_reg <= ones_next;
         samp_reg <= samp_next;
         half_reg <= half_next;
         chop_reg <= chop_next;
         sel_ext_reg <= sel_ext_next;
         raw_reg <= raw_next;
         itemp_res_reg <= itemp_res_next;
         etemp_res_reg <= etemp_res_next;
         cal_reg <= cal_next;
         temp_run_reg <= temp_run_next;
         supply_reg <= supply_next;
      end
   end

   // ************************************************
   // Outputs
   // ************************************************

   // Every output is a flip-flop; temp_run ignores low power on purpose.
   assign reg_rdata = rdata_reg;
   assign cur_run = cur_run_reg;
   assign volt_run = volt_run_reg;
   assign temp_run = temp_run_reg;
   assign cur_start = cur_start_reg;
   assign volt_start = volt_start_reg;
   assign cur_irq_req = cur_irq_reg;
   assign volt_irq_req = volt_irq_reg;
   assign temp_chop_phase = chop_reg;
   assign temp_sel_ext = sel_ext_reg;
   assign external_sensor_supply_output = supply_reg;
   assign cal_request = cal_reg;

endmodule // mrt_top

/* tb/mrt_monitor.sv */
`timescale 1ns/10ps
module mrt_monitor (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic low_power_mode,
   input wire logic cur_valid,
   input wire logic volt_valid,
   input wire logic cur_run,
   input wire logic volt_run,
   input wire logic temp_run,
   input wire logic cur_start,
   input wire logic volt_start,
   input wire logic cur_irq_req,
   input wire logic volt_irq_req,
   input wire logic temp_chop_phase,
   input wire logic temp_sel_ext,
   input wire logic external_sensor_supply_output
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic sel_prev_reg;
   logic [7:0] sel_cnt_reg;
   // Cycles since the sensor select last moved, held at zero while idle; saturating so a long single-sensor run never wraps.
   always_ff @(posedge sys_clk) begin
      sel_prev_reg <= temp_sel_ext;
      if (rst || !temp_run || temp_sel_ext != sel_prev_reg) sel_cnt_reg <= 8'h00;
      else if (sel_cnt_reg != 8'hff) sel_cnt_reg <= sel_cnt_reg + 8'h01;
   end
   // ****
   // Assertions
   // ****
   start_sync_a: assert property (reg_wr && reg_addr == 8'h00 && reg_wdata[1:0] == 2'b11
      && !cur_run && !volt_run && !low_power_mode |=> cur_start && volt_start) else $error("starts not together");
   start_pulse_a: assert property (cur_start |=> !cur_start) else $error("start pulse too long");
   cur_irq_a: assert property (cur_irq_req |-> $past(cur_valid) && $past(cur_run)) else $error("stray current irq");
   volt_irq_a: assert property (volt_irq_req |-> $past(volt_valid) && $past(volt_run)) else $error("stray volt irq");
   lp_cur_keep_a: assert property (low_power_mode && cur_run && !reg_wr |=> cur_run) else $error("current stopped");
   lp_volt_stop_a: assert property (low_power_mode [*2] |-> !volt_run) else $error("voltage runs in low power");
   supply_ext_a: assert property (external_sensor_supply_output |-> temp_sel_ext && temp_run)
      else $error("supply without external conversion");
   sel_hold_a: assert property (temp_run && $past(temp_run) && $changed(temp_sel_ext) |-> sel_cnt_reg >= 8'd120)
      else $error("sensor switched before decimation end");
   chop_run_a: assert property ($rose(temp_chop_phase) |-> temp_run) else $error("chop while idle");
   int_first_a: assert property ($rose(temp_run) |-> !temp_sel_ext) else $error("external sensor first");
   cover property (cur_irq_req && volt_irq_req);
   cover property (cur_start && volt_start);
   cover property ($rose(temp_sel_ext));
endmodule // mrt_monitor
bind mrt_top mrt_monitor mon (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .low_power_mode, .cur_valid,
   .volt_valid, .cur_run, .volt_run, .temp_run, .cur_start, .volt_start, .cur_irq_req, .volt_irq_req,
   .temp_chop_phase, .temp_sel_ext, .external_sensor_supply_output);

/* tb/mrt_modulator_model.sv */
`timescale 1ns/10ps
module mrt_modulator_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic temp_run,
   input wire logic temp_chop_phase,
   input wire logic [1:0] pattern_mode,
   output logic temp_bit,
   output logic temp_bit_valid
);
   logic alt_reg;
   // One bit per cycle while the channel runs, from the one shared converter for both sensors.
   always_ff @(posedge sys_clk) begin
      temp_bit_valid <= temp_run && !rst;
      alt_reg <= rst ? 1'b0 : !alt_reg;
   end
   // Pattern 0 is all zeros, 1 all ones, both inverted in chopper phase 1, 2 alternating; an idle line toggles so no stale level is read.
   always_comb begin
      if (!temp_bit_valid || pattern_mode == 2'd2) temp_bit = alt_reg;
      else temp_bit = pattern_mode[0] ^ temp_chop_phase;
   end
endmodule // mrt_modulator_model

/* tb/measurement_result_temperature_channel_tb.sv */
`timescale 1ns/10ps
module measurement_result_temperature_channel_tb;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic low_power_mode = 1'b0;
   logic [23:0] cur_data = 24'h000000;
   logic [2:0] cur_gain = 3'h0;
   logic cur_valid = 1'b0;
   logic [19:0] volt_data = 20'h00000;
   logic volt_valid = 1'b0;
   logic trim_load = 1'b0;
   logic [7:0] trim_internal_temp_gain_code = 8'h00;
   logic [7:0] trim_internal_temp_offset_code = 8'h00;
   logic [1:0] pattern_mode = 2'h0;
   logic [15:0] reg_rdata, rd_val, last_v;
   logic temp_bit, temp_bit_valid, cur_run, volt_run, temp_run, cur_start, volt_start, cur_irq_req;
   logic volt_irq_req, temp_chop_phase, temp_sel_ext, external_sensor_supply_output, cal_request;
   logic [31:0] lfsr = 32'd46;
   logic [23:0] d, w;
   logic [19:0] vd;
   int errors = 0;
   int samples_checked = 0;
   logic [7:0] r_addr [6] = '{8'h00, 8'h0c, 8'h0e, 8'h10, 8'h12, 8'hfe};
   logic [15:0] r_val [6] = '{16'h0000, 16'h0080, 16'h0000, 16'h0080, 16'h0000, 16'h0000};
   logic [23:0] c_corner [6] = '{24'h7fffff, 24'h800000, 24'h00ffff, 24'h010000, 24'hff0000, 24'hfeffff};
   logic [19:0] v_corner [6] = '{20'h7ffff, 20'h80000, 20'h0ffff, 20'h10000, 20'h00000, 20'hfffff};
   logic [1:0] t_mode [6] = '{2'd1, 2'd0, 2'd2, 2'd2, 2'd2, 2'd0};
   logic [7:0] t_gain [6] = '{8'h80, 8'h80, 8'h00, 8'hff, 8'h80, 8'h80};
   logic [7:0] t_off [6] = '{8'h00, 8'h7f, 8'h00, 8'h80, 8'h00, 8'h80};
   mrt_top dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .low_power_mode, .cur_data,
      .cur_gain, .cur_valid, .volt_data, .volt_valid, .temp_bit, .temp_bit_valid, .trim_load, .trim_internal_temp_gain_code,
      .trim_internal_temp_offset_code, .cur_run, .volt_run, .temp_run, .cur_start, .volt_start, .cur_irq_req, .volt_irq_req,
      .temp_chop_phase, .temp_sel_ext, .external_sensor_supply_output, .cal_request);
   mrt_modulator_model model (.sys_clk, .rst, .temp_run, .temp_chop_phase, .pattern_mode, .temp_bit,
      .temp_bit_valid);
   // ****
   // Helpers
   // ****
   always #4 sys_clk = ~sys_clk;
   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Current word: gain on top, 17-bit clamped two's complement below.
   function automatic logic [23:0] cur_exp(input logic [23:0] x, input logic [2:0] g);
      logic [16:0] c;
      if (!x[23] && x > 24'h00ffff) c = 17'h0ffff;
      else if (x[23] && x < 24'hff0000) c = 17'h10000;
      else c = x[16:0];
      return {g, 4'h0, c};
   endfunction
   function automatic logic [15:0] volt_exp(input logic [19:0] x);
      if (x[19]) return 16'h0000;
      if (x > 20'h0ffff) return 16'hffff;
      return x[15:0];
   endfunction
   // Saturation is applied before and after compensation, so neither stage can wrap.
   function automatic logic [15:0] temp_exp(input int ones, input logic [7:0] g, input logic [7:0] o);
      int v;
      v = ones * 512;
      if (v > 65535) v = 65535;
      v = ((v * (896 + int'(g))) >>> 10) + int'($signed(o)) * 4;
      if (v < 0) v = 0;
      if (v > 65535) v = 65535;
      return 16'(v);
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] expected);
      samples_checked++;
      if (seen !== expected) begin
         errors++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, expected);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      rd_val = reg_rdata;
   endtask
   task automatic sample(input logic [23:0] c, input logic [2:0] g, input logic [19:0] v);
      @(posedge sys_clk);
      cur_data <= c;
      cur_gain <= g;
      volt_data <= v;
      cur_valid <= 1'b1;
      volt_valid <= 1'b1;
      @(posedge sys_clk);
      cur_valid <= 1'b0;
      volt_valid <= 1'b0;
      #1;
   endtask
   task automatic wait_sel(input logic v);
      int n;
      n = 0;
      while (temp_sel_ext !== v && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      #1;
      check(16'(temp_sel_ext), 16'(v));
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // A hung handshake would otherwise stall the run forever.
   initial begin
      #(8 * 20000);
      errors++;
      stop_test();
   end
   // ****
   // Tests
   // ****
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      foreach (r_addr[i]) begin
         rd(r_addr[i]);
         check(rd_val, r_val[i]);
      end
      $display("reset values done");
      wr(8'h00, 16'h0063);
      #1;
      check(16'({cur_start, volt_start}), 16'h0003);
      for (int i = 0; i < 24; i++) begin
         lfsr = lfsr_next(lfsr);
         d = (i < 6) ? c_corner[i] : lfsr[23:0];
         vd = (i < 6) ? v_corner[i] : lfsr[31:12];
         if (i == 16) wr(8'h00, 16'h0003);
         sample(d, lfsr[26:24], vd);
         check(16'({cur_irq_req, volt_irq_req}), (i < 16) ? 16'h0003 : 16'h0000);
         w = cur_exp(d, lfsr[26:24]);
         rd(8'h02);
         check(rd_val, {8'h00, w[23:16]});
         rd(8'h04);
         check(rd_val, w[15:0]);
         rd(8'h06);
         check(rd_val, volt_exp(vd));
      end
      last_v = volt_exp(vd);
      $display("current and voltage done");
      @(posedge sys_clk);
      low_power_mode <= 1'b1;
      repeat (2) @(posedge sys_clk);
      sample(24'h000123, 3'h5, 20'h01234);
      check(16'({cur_run, volt_run}), 16'h0002);
      rd(8'h04);
      check(rd_val, 16'h0123);
      rd(8'h06);
      check(rd_val, last_v);
      @(posedge sys_clk);
      low_power_mode <= 1'b0;
      wr(8'h00, 16'h0000);
      wr(8'h00, 16'h0003);
      #1;
      check(16'({cur_start, volt_start}), 16'h0003);
      $display("low power done");
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk);
         pattern_mode <= t_mode[i];
         wr(8'h0c, {8'h00, t_gain[i]});
         wr(8'h0e, {8'h00, t_off[i]});
         wr(8'h00, (i == 4) ? 16'h0014 : 16'h0004);
         repeat (700) @(posedge sys_clk);
         rd(8'h08);
         check(rd_val, temp_exp((t_mode[i] == 2'd1) ? 128 : 32 * t_mode[i], t_gain[i], t_off[i]));
         if (i < 2) check(16'(cal_request), (i == 0) ? 16'h0001 : 16'h0000);
      end
      $display("temperature done");
      @(posedge sys_clk);
      pattern_mode <= 2'd2;
      wr(8'h00, 16'h0000);
      wr(8'h00, 16'h000c);
      #1;
      check(16'(temp_sel_ext), 16'h0000);
      wait_sel(1'b1);
      check(16'(external_sensor_supply_output), 16'h0001);
      wait_sel(1'b0);
      rd(8'h0a);
      check(rd_val, 16'h8000);
      rd(8'h08);
      check(rd_val, temp_exp(64, 8'h80, 8'h80));
      $display("sensor sequence done");
      @(posedge sys_clk);
      trim_internal_temp_gain_code <= 8'h55;
      trim_internal_temp_offset_code <= 8'h11;
      trim_load <= 1'b1;
      @(posedge sys_clk);
      trim_load <= 1'b0;
      rd(8'h0c);
      check(rd_val, 16'h0055);
      rd(8'h0e);
      check(rd_val, 16'h0011);
      rd(8'h10);
      check(rd_val, 16'h0080);
      $display("trim done");
      stop_test();
   end
endmodule // measurement_result_temperature_channel_tb
